/* File: hdm_host.sv */
/*
  Host end: runs user commands as polled mailbox transfers and
  services IREQ by reading status, then clearing and re-arming.
  Assumes the device end answers each access with hostAck.
*/
`timescale 1ns/10ps
module hdm_host
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  hdm_if.host hif, // Device side
  input wire logic sendReq, // Pulse: send sendData inbound
  input wire logic [hdm_pkg::DATA_W-1:0] sendData, // Word to send
  input wire logic recvReq, // Pulse: fetch outbound word
  input wire logic [3:0] irqEnable, // Enables written on change and at service
  output logic busy, // Command in progress
  output logic recvValid, // Pulse: recvData valid
  output logic [hdm_pkg::DATA_W-1:0] recvData, // Word received
  output logic [hdm_pkg::DATA_W-1:0] lastStatus, // Status at IREQ
  output logic irqServiced // Pulse: IREQ serviced
);
  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  typedef enum logic [3:0]
  {
    HDM_H_IDLE = 4'b0000,
    HDM_H_POLL = 4'b0001,
    HDM_H_XFER = 4'b0010,
    HDM_H_ISTAT = 4'b0011,
    HDM_H_CLR = 4'b0100,
    HDM_H_ARM = 4'b0101,
    HDM_H_WAIT = 4'b0110,
    HDM_H_CFG = 4'b0111
  } hdm_host_t;

  hdm_host_t st_ff, nxt_st;
  hdm_host_t ret_ff, nxt_ret;
  logic isSend_ff, nxt_isSend;
  logic [hdm_pkg::DATA_W-1:0] data_ff, nxt_data;
  logic rd_ff, nxt_rd;
  logic wr_ff, nxt_wr;
  logic [1:0] sel_ff, nxt_sel;
  logic [hdm_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
  logic busy_ff, nxt_busy;
  logic rv_ff, nxt_rv;
  logic [hdm_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [hdm_pkg::DATA_W-1:0] stat_ff, nxt_stat;
  logic svc_ff, nxt_svc;
  logic [3:0] enW_ff, nxt_enW;
  logic irqPend_ff, nxt_irqPend;
  logic [hdm_pkg::DATA_W-1:0] ctrlWord;
  logic done;

  assign done = hif.hostAck && (rd_ff || wr_ff);

  always_comb
  begin
    ctrlWord = '0;
    ctrlWord[hdm_pkg::HC_TO_EN:hdm_pkg::HC_OUT_EN] = irqEnable;
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_ret = ret_ff;
    nxt_isSend = isSend_ff;
    nxt_data = data_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_sel = sel_ff;
    nxt_wdata = wdata_ff;
    nxt_busy = busy_ff;
    nxt_rv = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_stat = stat_ff;
    nxt_svc = 1'b0;
    nxt_enW = enW_ff;
    // Latch IREQ so a pulse seen while busy is still serviced
    nxt_irqPend = irqPend_ff || hif.ireq;
    if (done)
    begin
      nxt_rd = 1'b0;
      nxt_wr = 1'b0;
    end
    unique case (st_ff)
      HDM_H_IDLE:
      begin
        if (hif.ireq || irqPend_ff)
        begin
          nxt_st = HDM_H_ISTAT;
          nxt_rd = 1'b1;
          nxt_sel = hdm_pkg::HSEL_STATUS;
          nxt_busy = 1'b1;
        end
        else if (irqEnable != enW_ff)
        begin
          nxt_st = HDM_H_CFG;
          nxt_busy = 1'b1;
        end
        else if (sendReq || recvReq)
        begin
          nxt_st = HDM_H_POLL;
          nxt_isSend = sendReq;
          nxt_data = sendData;
          nxt_rd = 1'b1;
          nxt_sel = hdm_pkg::HSEL_STATUS;
          nxt_busy = 1'b1;
        end
      end
      HDM_H_POLL:
      begin
        if (done)
        begin
          if (isSend_ff ? hif.hostRdata[hdm_pkg::HS_IN_EMPTY]
                        : hif.hostRdata[hdm_pkg::HS_OUT_FULL])
          begin
            // Request must drop before the transfer is raised
            nxt_st = HDM_H_WAIT;
            nxt_ret = HDM_H_XFER;
            nxt_sel = hdm_pkg::HSEL_MBOX;
            nxt_wdata = data_ff;
          end
          else
          begin
            nxt_st = HDM_H_WAIT;
            nxt_ret = HDM_H_POLL;
          end
        end
      end
      HDM_H_XFER:
      begin
        if (done)
        begin
          nxt_st = HDM_H_WAIT;
          nxt_ret = HDM_H_IDLE;
          nxt_rv = !isSend_ff;
          nxt_rdata = isSend_ff ? rdata_ff : hif.hostRdata;
        end
      end
      HDM_H_ISTAT:
      begin
        if (done)
        begin
          nxt_stat = hif.hostRdata;
          nxt_st = HDM_H_CLR;
        end
      end
      HDM_H_CLR:
      begin
        if (!rd_ff && !wr_ff && !hif.hostAck)
        begin
          nxt_wr = 1'b1;
          nxt_sel = hdm_pkg::HSEL_CTRL;
          nxt_wdata = ctrlWord;
        end
        else if (done)
        begin
          nxt_st = HDM_H_ARM;
        end
      end
      HDM_H_ARM:
      begin
        nxt_irqPend = 1'b0;
        if (!rd_ff && !wr_ff && !hif.hostAck)
        begin
          nxt_wr = 1'b1;
          nxt_wdata = ctrlWord;
          nxt_wdata[hdm_pkg::HC_REARM] = 1'b1;
          nxt_enW = irqEnable;
        end
        else if (done)
        begin
          nxt_st = HDM_H_WAIT;
          nxt_ret = HDM_H_IDLE;
          nxt_svc = 1'b1;
        end
      end
      HDM_H_WAIT:
      begin
        if (!hif.hostAck)
        begin
          nxt_st = ret_ff;
          if (ret_ff == HDM_H_POLL)
          begin
            nxt_rd = 1'b1;
          end
          else if (ret_ff == HDM_H_XFER)
          begin
            nxt_wr = isSend_ff;
            nxt_rd = !isSend_ff;
          end
          else
          begin
            nxt_busy = 1'b0;
          end
        end
      end
      HDM_H_CFG:
      begin
        // Enables change: write them with the re-arm bit set
        if (!rd_ff && !wr_ff && !hif.hostAck)
        begin
          nxt_wr = 1'b1;
          nxt_sel = hdm_pkg::HSEL_CTRL;
          nxt_wdata = ctrlWord;
          nxt_wdata[hdm_pkg::HC_REARM] = 1'b1;
          nxt_enW = irqEnable;
        end
        else if (done)
        begin
          nxt_st = HDM_H_WAIT;
          nxt_ret = HDM_H_IDLE;
        end
      end
      default: nxt_st = HDM_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= HDM_H_IDLE;
      ret_ff <= HDM_H_IDLE;
      isSend_ff <= 1'b0;
      data_ff <= '0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      sel_ff <= hdm_pkg::HSEL_STATUS;
      wdata_ff <= '0;
      busy_ff <= 1'b0;
      rv_ff <= 1'b0;
      rdata_ff <= '0;
      stat_ff <= '0;
      svc_ff <= 1'b0;
      enW_ff <= 4'h0;
      irqPend_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      st_ff <= nxt_st;
      ret_ff <= nxt_ret;
      isSend_ff <= nxt_isSend;
      data_ff <= nxt_data;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      sel_ff <= nxt_sel;
      wdata_ff <= nxt_wdata;
      busy_ff <= nxt_busy;
      rv_ff <= nxt_rv;
      rdata_ff <= nxt_rdata;
      stat_ff <= nxt_stat;
      svc_ff <= nxt_svc;
      enW_ff <= nxt_enW;
      irqPend_ff <= nxt_irqPend;
    end
  end

  assign hif.hostAddr = '0;
  assign hif.hostRd = rd_ff;
  assign hif.hostWr = wr_ff;
  assign hif.hostSel = sel_ff;
  assign hif.hostWdata = wdata_ff;
  assign busy = busy_ff;
  assign recvValid = rv_ff;
  assign recvData = rdata_ff;
  assign lastStatus = stat_ff;
  assign irqServiced = svc_ff;
endmodule : hdm_host

/* File: hdm_pkg.sv */
/*
  Shared constants for the host/DSP mailbox: data width, status bit
  positions, reset values and access latency counts.
  Assumes both ends share one clock and one active-low reset.
*/
package hdm_pkg;
  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 26;
  localparam int UPPER_LO = 16;
  localparam int CLK_NS = 10;
  localparam int SYSCLK_NS = 50;
  localparam int SYS_PER_CYC = (SYSCLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_SYS_CYC = 2;
  localparam int RD_SYS_CYC = 2;
  localparam int DEC_SYS_CYC = 1;
  localparam int WR_CYC = (WR_SYS_CYC + DEC_SYS_CYC) * SYS_PER_CYC;
  localparam int RD_CYC = (RD_SYS_CYC + DEC_SYS_CYC) * SYS_PER_CYC;
  // ----------------------------------------
  // Host register select codes
  // ----------------------------------------
  localparam logic [1:0] HSEL_STATUS = 2'h0;
  localparam logic [1:0] HSEL_MBOX = 2'h1;
  localparam logic [1:0] HSEL_CTRL = 2'h2;
  // ----------------------------------------
  // Host status bit positions
  // ----------------------------------------
  localparam int HS_OUT_FULL = 0;
  localparam int HS_IN_EMPTY = 1;
  localparam int HS_FE_IRQ = 2;
  localparam int HS_TIMEOUT = 3;
  localparam int HS_IREQ = 4;
  // Host control bit positions
  localparam int HC_OUT_EN = 0;
  localparam int HC_IN_EN = 1;
  localparam int HC_FE_EN = 2;
  localparam int HC_TO_EN = 3;
  localparam int HC_REARM = 12;
  // DSP-side status bit positions
  localparam int DS_IN_FULL = 0;
  localparam int DS_OUT_EMPTY = 1;
  // DSP register select codes
  localparam logic DSEL_STATUS = 1'h0;
  localparam logic DSEL_MBOX = 1'h1;
  // Reset values
  localparam logic RST_EMPTY = 1'h1;
  localparam logic RST_FULL = 1'h0;
  localparam logic RST_ARMED = 1'h1;
endpackage : hdm_pkg

/* File: hdm_if.sv */
/*
  Interface joining the mailbox device end to the host end.
  Assumes the testbench supplies clk and rst_n.
*/
`timescale 1ns/10ps
interface hdm_if
(
  input wire logic clk, // System clock
  input wire logic rst_n // Async reset, active low
);
  logic [hdm_pkg::ADDR_W-1:0] hostAddr;
  logic [1:0] hostSel;
  logic hostRd;
  logic hostWr;
  logic [hdm_pkg::DATA_W-1:0] hostWdata;
  logic [hdm_pkg::DATA_W-1:0] hostRdata;
  logic hostAck;
  logic ireq;

  modport device
  (
    input hostAddr, hostSel, hostRd, hostWr, hostWdata,
    output hostRdata, hostAck, ireq
  );
  modport host
  (
    output hostAddr, hostSel, hostRd, hostWr, hostWdata,
    input hostRdata, hostAck, ireq
  );
endinterface : hdm_if

/* File: hdm_device.sv */
/*
  Mailbox device end: two one-word mailboxes, empty/full flags,
  host IREQ with clear and re-arm, DSP interrupt lines.
  Assumes the host holds a request until hostAck, and that DSP
  strobes are one-cycle pulses synchronous to clk.
*/
// How it works
// - Inbound full drives DSP line a
// - Outbound empty raises DSP transmit interrupt
// - Transmit interrupt on line a, optionally b
// - Front-end interrupt to line d and IREQ
// - Host writes 0 then 1 to re-arm
// - Pulsed mode gives one IREQ per arming
// - Host polls outbound full before reading
// - Host read clears outbound full, sets empty
// - Host polls inbound empty before writing
// - Host write clears inbound empty, sets full
// - DSP polls inbound full before reading
// - DSP read clears inbound full, sets empty
// - DSP polls outbound empty before writing
// - DSP write clears outbound empty, sets full
// - Host reads status before clearing IREQ
// - Register write/read take two system cycles
// - Upper address zero check adds one system cycle
// - IREQ ORs four enabled sources
// - Disabling a source only masks it
`timescale 1ns/10ps
module hdm_device
#(
  parameter bit TX_ON_LINE_B = 1'b0 // Transmit interrupt on line b
)
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  hdm_if.device hif, // Host side
  input wire logic dspRd, // DSP register read strobe
  input wire logic dspWr, // DSP register write strobe
  input wire logic dspSel, // DSP register select
  input wire logic [hdm_pkg::DATA_W-1:0] dspWdata, // DSP write data
  output logic [hdm_pkg::DATA_W-1:0] dspRdata, // DSP read data
  input wire logic frontEndIrq, // Front-end card interrupt
  input wire logic busTimeoutFlag, // Bus timeout condition
  input wire logic pulsedMode, // IREQ pulses once per arming
  output logic dspIrqLineA_n, // DSP interrupt line a
  output logic dspIrqLineB_n, // DSP interrupt line b
  output logic dspIrqLineD_n // DSP interrupt line d
);
  // ----------------------------------------
  // Host access sequencer
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    HDM_IDLE = 2'b00,
    HDM_BUSY = 2'b01,
    HDM_DONE = 2'b10
  } hdm_acc_t;

  hdm_acc_t acc_ff, nxt_acc;
  logic [4:0] cnt_ff, nxt_cnt;
  logic wrOp_ff, nxt_wrOp;
  logic ack_ff, nxt_ack;
  logic [hdm_pkg::DATA_W-1:0] hRdata_ff, nxt_hRdata;
  logic upperZero;
  logic hostRdMbox;
  logic hostWrMbox;
  logic hostWrCtrl;

  // ----------------------------------------
  // Mailbox state
  // ----------------------------------------
  logic [hdm_pkg::DATA_W-1:0] inMbox_ff, nxt_inMbox;
  logic [hdm_pkg::DATA_W-1:0] outMbox_ff, nxt_outMbox;
  logic inFull_ff, nxt_inFull;
  logic outFull_ff, nxt_outFull;
  logic [3:0] irqEn_ff, nxt_irqEn;
  logic armed_ff, nxt_armed;
  logic ireq_ff, nxt_ireq;
  logic [hdm_pkg::DATA_W-1:0] dRdata_ff, nxt_dRdata;
  logic lineA_ff, nxt_lineA;
  logic lineB_ff, nxt_lineB;
  logic lineD_ff, nxt_lineD;
  logic [3:0] srcRaw;
  logic ireqCond;
  logic [hdm_pkg::DATA_W-1:0] hostStatus;
  logic [hdm_pkg::DATA_W-1:0] hostCtrl;
  logic [hdm_pkg::DATA_W-1:0] dspStatus;

  assign upperZero = ~|hif.hostAddr[hdm_pkg::ADDR_W-1:hdm_pkg::UPPER_LO];
  assign hostRdMbox = (acc_ff == HDM_BUSY) && (cnt_ff == 5'h0) && !wrOp_ff
                      && (hif.hostSel == hdm_pkg::HSEL_MBOX);
  assign hostWrMbox = (acc_ff == HDM_BUSY) && (cnt_ff == 5'h0) && wrOp_ff
                      && (hif.hostSel == hdm_pkg::HSEL_MBOX);
  assign hostWrCtrl = (acc_ff == HDM_BUSY) && (cnt_ff == 5'h0) && wrOp_ff
                      && (hif.hostSel == hdm_pkg::HSEL_CTRL);

  assign srcRaw = {busTimeoutFlag, frontEndIrq, ~inFull_ff, outFull_ff};
  assign ireqCond = |(srcRaw & irqEn_ff);

  always_comb
  begin
    hostStatus = '0;
    hostStatus[hdm_pkg::HS_OUT_FULL] = outFull_ff;
    hostStatus[hdm_pkg::HS_IN_EMPTY] = ~inFull_ff;
    hostStatus[hdm_pkg::HS_FE_IRQ] = frontEndIrq;
    hostStatus[hdm_pkg::HS_TIMEOUT] = busTimeoutFlag;
    hostStatus[hdm_pkg::HS_IREQ] = ireq_ff;
    hostCtrl = '0;
    hostCtrl[hdm_pkg::HC_TO_EN:hdm_pkg::HC_OUT_EN] = irqEn_ff;
    hostCtrl[hdm_pkg::HC_REARM] = armed_ff;
    dspStatus = '0;
    dspStatus[hdm_pkg::DS_IN_FULL] = inFull_ff;
    dspStatus[hdm_pkg::DS_OUT_EMPTY] = ~outFull_ff;
  end

  // ----------------------------------------
  // Host access next state
  // ----------------------------------------
  always_comb
  begin
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_wrOp = wrOp_ff;
    nxt_ack = 1'b0;
    nxt_hRdata = hRdata_ff;
    unique case (acc_ff)
      HDM_IDLE:
      begin
        if ((hif.hostRd || hif.hostWr) && upperZero)
        begin
          nxt_acc = HDM_BUSY;
          nxt_wrOp = hif.hostWr;
          nxt_cnt = hif.hostWr ? 5'(hdm_pkg::WR_CYC - 1)
                               : 5'(hdm_pkg::RD_CYC - 1);
        end
      end
      HDM_BUSY:
      begin
        if (cnt_ff == 5'h0)
        begin
          nxt_acc = HDM_DONE;
          nxt_ack = 1'b1;
          unique case (hif.hostSel)
            hdm_pkg::HSEL_STATUS: nxt_hRdata = hostStatus;
            hdm_pkg::HSEL_MBOX: nxt_hRdata = outMbox_ff;
            hdm_pkg::HSEL_CTRL: nxt_hRdata = hostCtrl;
            default: nxt_hRdata = '0;
          endcase
        end
        else
        begin
          nxt_cnt = cnt_ff - 5'h1;
        end
      end
      HDM_DONE:
      begin
        if (!hif.hostRd && !hif.hostWr)
        begin
          nxt_acc = HDM_IDLE;
        end
      end
      default: nxt_acc = HDM_IDLE;
    endcase
  end

  // ----------------------------------------
  // Mailbox, flags and interrupts next state
  // ----------------------------------------
  always_comb
  begin
    nxt_inMbox = inMbox_ff;
    nxt_outMbox = outMbox_ff;
    nxt_inFull = inFull_ff;
    nxt_outFull = outFull_ff;
    nxt_irqEn = irqEn_ff;
    nxt_armed = armed_ff;
    nxt_ireq = ireq_ff;
    nxt_dRdata = dRdata_ff;
    // Each flag has one setter and one clearer; setter wins
    if (dspRd && dspSel == hdm_pkg::DSEL_MBOX)
    begin
      nxt_inFull = 1'b0;
    end
    if (hostWrMbox)
    begin
      nxt_inMbox = hif.hostWdata;
      nxt_inFull = 1'b1;
    end
    if (hostRdMbox)
    begin
      nxt_outFull = 1'b0;
    end
    if (dspWr && dspSel == hdm_pkg::DSEL_MBOX)
    begin
      nxt_outMbox = dspWdata;
      nxt_outFull = 1'b1;
    end
    if (dspRd)
    begin
      nxt_dRdata = (dspSel == hdm_pkg::DSEL_MBOX) ? inMbox_ff : dspStatus;
    end
    if (hostWrCtrl)
    begin
      nxt_irqEn = hif.hostWdata[hdm_pkg::HC_TO_EN:hdm_pkg::HC_OUT_EN];
      nxt_armed = hif.hostWdata[hdm_pkg::HC_REARM];
    end
    // IREQ: level while armed, or a single pulse then disarm
    if (!armed_ff)
    begin
      nxt_ireq = 1'b0;
    end
    else if (pulsedMode)
    begin
      nxt_ireq = ireqCond && !ireq_ff;
      if (ireqCond && !ireq_ff && !hostWrCtrl)
      begin
        nxt_armed = 1'b0;
      end
    end
    else
    begin
      nxt_ireq = ireqCond;
    end
  end

  // DSP lines are active low
  always_comb
  begin
    nxt_lineA = ~(inFull_ff || (!TX_ON_LINE_B && !outFull_ff));
    nxt_lineB = ~(TX_ON_LINE_B && !outFull_ff);
    nxt_lineD = ~frontEndIrq;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff <= HDM_IDLE;
      cnt_ff <= 5'h0;
      wrOp_ff <= 1'b0;
      ack_ff <= 1'b0;
      hRdata_ff <= '0;
      inMbox_ff <= '0;
      outMbox_ff <= '0;
      inFull_ff <= hdm_pkg::RST_FULL;
      outFull_ff <= hdm_pkg::RST_FULL;
      irqEn_ff <= 4'h0;
      armed_ff <= hdm_pkg::RST_ARMED;
      ireq_ff <= 1'b0;
      dRdata_ff <= '0;
      lineA_ff <= 1'b1;
      lineB_ff <= 1'b1;
      lineD_ff <= 1'b1;
    end
    else if (clkEn)
    begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      wrOp_ff <= nxt_wrOp;
      ack_ff <= nxt_ack;
      hRdata_ff <= nxt_hRdata;
      inMbox_ff <= nxt_inMbox;
      outMbox_ff <= nxt_outMbox;
      inFull_ff <= nxt_inFull;
      outFull_ff <= nxt_outFull;
      irqEn_ff <= nxt_irqEn;
      armed_ff <= nxt_armed;
      ireq_ff <= nxt_ireq;
      dRdata_ff <= nxt_dRdata;
      lineA_ff <= nxt_lineA;
      lineB_ff <= nxt_lineB;
      lineD_ff <= nxt_lineD;
    end
  end

  assign hif.hostAck = ack_ff;
  assign hif.hostRdata = hRdata_ff;
  assign hif.ireq = ireq_ff;
  assign dspRdata = dRdata_ff;
  assign dspIrqLineA_n = lineA_ff;
  assign dspIrqLineB_n = lineB_ff;
  assign dspIrqLineD_n = lineD_ff;
endmodule : hdm_device

/* File: hdm_properties.sv */
/*
  Checker for the host register bus of the mailbox pair.
  Assumes one clock domain and instantiation beside the interface.
*/
`timescale 1ns/10ps
module hdm_properties
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [hdm_pkg::ADDR_W-1:0] hostAddr, // Host address
  input wire logic [1:0] hostSel, // Register select
  input wire logic hostRd, // Read request
  input wire logic hostWr, // Write request
  input wire logic [hdm_pkg::DATA_W-1:0] hostWdata, // Write data
  input wire logic [hdm_pkg::DATA_W-1:0] hostRdata, // Read data
  input wire logic hostAck, // Access answer
  input wire logic ireq // Host interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire req = hostRd | hostWr;
  wire upZero = hostAddr[hdm_pkg::ADDR_W-1:hdm_pkg::UPPER_LO] == '0;
  wire ctrlClr = hostAck && hostWr && hostSel == hdm_pkg::HSEL_CTRL
    && !hostWdata[hdm_pkg::HC_REARM];
  // ----
  // Handshake
  // ----
  AST_ACK_LATENCY: assert property (
    $rose(req) |-> (!hostAck)[*8] ##1 (!hostAck)[*6] ##[1:4] hostAck)
    else $error("Host access answered outside its window");
  AST_ACK_ONE: assert property (hostAck |=> !hostAck)
    else $error("Host answer longer than one cycle");
  AST_ACK_HELD: assert property (hostAck |-> req)
    else $error("Host answer without a held request");
  AST_REQ_STABLE: assert property (
    req && !hostAck |=> $stable({hostRd, hostWr, hostSel, hostWdata}))
    else $error("Host request changed before its answer");
  AST_REQ_DROP: assert property (hostAck |=> !req)
    else $error("Host request not dropped after answer");
  AST_UPPER_ZERO: assert property ((req || hostAck) |-> upZero)
    else $error("Access with nonzero upper address");
  AST_RDATA_HOLD: assert property (
    !hostAck |=> hostAck || $stable(hostRdata))
    else $error("Read data moved without an answer");
  // ----
  // Interrupt request
  // ----
  AST_IREQ_RESET: assert property ($rose(rst_n) |-> !ireq)
    else $error("Interrupt request high out of reset");
  AST_IREQ_CLEAR: assert property (ctrlClr |-> ##2 (!ireq)[*3])
    else $error("Interrupt request not cleared by disarm");
  COV_MBOX_READ: cover property (
    hostAck && hostRd && hostSel == hdm_pkg::HSEL_MBOX);
  COV_IREQ: cover property ($rose(ireq));
  COV_DISARM: cover property (ctrlClr);
endmodule : hdm_properties

/* File: hdm_tb_top.sv */
/*
  Self-checking bench: host end and device end joined by hdm_if.
  Assumes the design and checker files are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) \
    begin \
      errCount++; \
      $display("CHECK FAILED at %0t: got %h, expected %h", \
        $time, (got), (exp)); \
    end \
  end
module hdm_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic dspRd = 1'b0;
  logic dspWr = 1'b0;
  logic dspSel = 1'b0;
  logic [hdm_pkg::DATA_W-1:0] dspWdata = '0;
  logic [hdm_pkg::DATA_W-1:0] dspRdata;
  logic frontEndIrq = 1'b0;
  logic busTimeoutFlag = 1'b0;
  logic pulsedMode = 1'b0;
  logic lineA_n, lineB_n, lineD_n;
  logic sendReq = 1'b0;
  logic [hdm_pkg::DATA_W-1:0] sendData = '0;
  logic recvReq = 1'b0;
  logic [3:0] irqEnable = 4'h0;
  logic busy, recvValid, irqServiced;
  logic [hdm_pkg::DATA_W-1:0] recvData, lastStatus, word;
  int errCount = 0;
  int testsRun = 0;
  int cycles = 0;
  hdm_if hif (.clk(clk), .rst_n(rst_n));
  hdm_device #(.TX_ON_LINE_B(1'b0)) u_hdm_device (.clk(clk),
    .rst_n(rst_n), .clkEn(clkEn), .hif(hif.device), .dspRd(dspRd),
    .dspWr(dspWr), .dspSel(dspSel), .dspWdata(dspWdata),
    .dspRdata(dspRdata), .frontEndIrq(frontEndIrq),
    .busTimeoutFlag(busTimeoutFlag), .pulsedMode(pulsedMode),
    .dspIrqLineA_n(lineA_n), .dspIrqLineB_n(lineB_n),
    .dspIrqLineD_n(lineD_n));
  hdm_host u_hdm_host (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .hif(hif.host), .sendReq(sendReq), .sendData(sendData),
    .recvReq(recvReq), .irqEnable(irqEnable), .busy(busy),
    .recvValid(recvValid), .recvData(recvData),
    .lastStatus(lastStatus), .irqServiced(irqServiced));
  hdm_properties u_hdm_properties (.clk(clk), .rst_n(rst_n),
    .hostAddr(hif.hostAddr), .hostSel(hif.hostSel),
    .hostRd(hif.hostRd), .hostWr(hif.hostWr),
    .hostWdata(hif.hostWdata), .hostRdata(hif.hostRdata),
    .hostAck(hif.hostAck), .ireq(hif.ireq));
  always #5 clk = ~clk;
  // ----
  // Hang guard
  // ----
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      finishTest();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic finishTest();
    $display("Checks run %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finishTest
  task automatic dspAccess(input logic wr, input logic sel,
    input logic [hdm_pkg::DATA_W-1:0] wdata);
    @(posedge clk);
    dspWr <= wr;
    dspRd <= !wr;
    dspSel <= sel;
    dspWdata <= wdata;
    @(posedge clk);
    dspWr <= 1'b0;
    dspRd <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : dspAccess
  task automatic dspStatus(input logic inFull, input logic outEmpty);
    dspAccess(1'b0, hdm_pkg::DSEL_STATUS, '0);
    `CHK(dspRdata[hdm_pkg::DS_IN_FULL], inFull);
    `CHK(dspRdata[hdm_pkg::DS_OUT_EMPTY], outEmpty);
  endtask : dspStatus
  task automatic waitIdle();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clk);
    @(negedge clk);
    `CHK(busy, 1'b0);
  endtask : waitIdle
  task automatic sendWord(input logic [hdm_pkg::DATA_W-1:0] w);
    @(posedge clk);
    sendReq <= 1'b1;
    sendData <= w;
    @(posedge clk);
    sendReq <= 1'b0;
    waitIdle();
  endtask : sendWord
  task automatic recvWord(output logic [hdm_pkg::DATA_W-1:0] w);
    @(posedge clk);
    recvReq <= 1'b1;
    @(posedge clk);
    recvReq <= 1'b0;
    for (int i = 0; i < 3000 && recvValid !== 1'b1; i++)
      @(posedge clk);
    w = recvData;
    waitIdle();
  endtask : recvWord
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(hif.ireq, 1'b0);
    dspStatus(1'b0, 1'b1);
    `CHK(lineA_n, 1'b0);
    `CHK(lineB_n, 1'b1);
    `CHK(lineD_n, 1'b1);
    @(posedge clk);
    clkEn <= 1'b0;
    dspAccess(1'b1, hdm_pkg::DSEL_MBOX, 16'h5555);
    @(posedge clk);
    clkEn <= 1'b1;
    dspStatus(1'b0, 1'b1);
    sendWord(16'h1234);
    dspStatus(1'b1, 1'b1);
    `CHK(lineA_n, 1'b0);
    dspAccess(1'b0, hdm_pkg::DSEL_MBOX, '0);
    `CHK(dspRdata, 16'h1234);
    dspStatus(1'b0, 1'b1);
    dspAccess(1'b1, hdm_pkg::DSEL_MBOX, 16'habcd);
    dspStatus(1'b0, 1'b0);
    `CHK(lineA_n, 1'b1);
    recvWord(word);
    `CHK(word, 16'habcd);
    dspStatus(1'b0, 1'b1);
    sendWord(16'h0001);
    fork
      sendWord(16'hfffe);
      begin
        repeat (60) @(posedge clk);
        `CHK(busy, 1'b1);
        dspAccess(1'b0, hdm_pkg::DSEL_MBOX, '0);
        `CHK(dspRdata, 16'h0001);
      end
    join
    dspAccess(1'b0, hdm_pkg::DSEL_MBOX, '0);
    `CHK(dspRdata, 16'hfffe);
    @(posedge clk);
    irqEnable <= 4'h4;
    frontEndIrq <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(lineD_n, 1'b0);
    for (int i = 0; i < 3000 && irqServiced !== 1'b1; i++)
      @(negedge clk);
    `CHK(irqServiced, 1'b1);
    `CHK(lastStatus[hdm_pkg::HS_FE_IRQ], 1'b1);
    @(posedge clk);
    frontEndIrq <= 1'b0;
    waitIdle();
    repeat (40) @(posedge clk);
    @(negedge clk);
    `CHK(hif.ireq, 1'b0);
    `CHK(lineD_n, 1'b1);
    @(posedge clk);
    pulsedMode <= 1'b1;
    irqEnable <= 4'h8;
    busTimeoutFlag <= 1'b1;
    for (int i = 0; i < 3000 && hif.ireq !== 1'b1; i++)
      @(negedge clk);
    `CHK(hif.ireq, 1'b1);
    @(negedge clk);
    `CHK(hif.ireq, 1'b0);
    for (int i = 0; i < 3000 && irqServiced !== 1'b1; i++)
      @(negedge clk);
    `CHK(irqServiced, 1'b1);
    `CHK(lastStatus[hdm_pkg::HS_TIMEOUT], 1'b1);
    @(posedge clk);
    busTimeoutFlag <= 1'b0;
    waitIdle();
    repeat (40) @(posedge clk);
    @(negedge clk);
    `CHK(hif.ireq, 1'b0);
    finishTest();
  end
endmodule : hdm_tb_top
